// File: inc/gpp_pkg.sv
// Purpose: Shared constants for the 32-pin port block
// Assumes: 32-bit register port, word offsets as byte addresses
// Notes:   Offsets of set/clear aliases follow their base register
package gpp_pkg;
	localparam int unsigned NPINS = 32;
	localparam int unsigned AW    = 8;
	localparam logic [AW-1:0] A_SEL0     = 8'h00;
	localparam logic [AW-1:0] A_SEL0_SET = 8'h04;
	localparam logic [AW-1:0] A_SEL0_CLR = 8'h08;
	localparam logic [AW-1:0] A_DRV_EN   = 8'h0C;
	localparam logic [AW-1:0] A_DRV_EN_SET = 8'h10;
	localparam logic [AW-1:0] A_DRV_EN_CLR = 8'h14;
	localparam logic [AW-1:0] A_DRV_LVL  = 8'h18;
	localparam logic [AW-1:0] A_DRV_LVL_SET = 8'h1C;
	localparam logic [AW-1:0] A_DRV_LVL_CLR = 8'h20;
	localparam logic [AW-1:0] A_IN_LVL   = 8'h24;
	localparam logic [AW-1:0] A_IRQ_EN   = 8'h28;
	localparam logic [AW-1:0] A_IRQ_EN_SET = 8'h2C;
	localparam logic [AW-1:0] A_IRQ_EN_CLR = 8'h30;
	localparam logic [AW-1:0] A_IRQ_FL   = 8'h34;
	localparam logic [AW-1:0] A_IRQ_FL_CLR = 8'h38;
	localparam logic [AW-1:0] A_SEL1     = 8'h3C;
	localparam logic [AW-1:0] A_SEL1_SET = 8'h40;
	localparam logic [AW-1:0] A_SEL1_CLR = 8'h44;
	localparam logic [AW-1:0] A_SEL2     = 8'h48;
	localparam logic [AW-1:0] A_SEL2_SET = 8'h4C;
	localparam logic [AW-1:0] A_SEL2_CLR = 8'h50;
	localparam logic [AW-1:0] A_TRIG     = 8'h54;
	localparam logic [AW-1:0] A_POL      = 8'h58;
	localparam logic [AW-1:0] A_RX_EN    = 8'h5C;
	localparam logic [AW-1:0] A_RX_EN_SET = 8'h60;
	localparam logic [AW-1:0] A_RX_EN_CLR = 8'h64;
	localparam logic [AW-1:0] A_PULL0    = 8'h68;
	localparam logic [AW-1:0] A_PULL1    = 8'h6C;
	localparam logic [AW-1:0] A_PSTR     = 8'h70;
	localparam logic [AW-1:0] A_DS0      = 8'h74;
	localparam logic [AW-1:0] A_DS1      = 8'h78;
	localparam logic [AW-1:0] A_RAIL     = 8'h7C;
	localparam logic [AW-1:0] A_BOTH     = 8'h80;
	localparam logic [AW-1:0] A_WAKE_EN  = 8'h84;
	localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
	localparam logic [31:0] ZERO32   = 32'h0000_0000;
	// Debug pins come up in the primary alternate function
	localparam logic [31:0] DBG_PINS = 32'h3000_0000;
	localparam logic [31:0] RST_SEL0 = ALL_ONES & ~DBG_PINS;
	localparam logic [31:0] RST_RXEN = ALL_ONES;
	// Pull code values
	localparam logic [1:0] PULL_HIZ  = 2'h0;
	localparam logic [1:0] PULL_UP   = 2'h1;
	localparam logic [1:0] PULL_DOWN = 2'h2;
endpackage

// File: inc/gpp_det_if.sv
// Purpose: Carries input levels and detector controls between modules
// Assumes: One clock, 32 pins
// Notes:   Controller drives config, detector returns events
`timescale 1ns/1ps
`default_nettype none
interface gpp_det_if;
	logic [31:0] lvl;
	logic [31:0] trig_edge;
	logic [31:0] pol_fall;
	logic [31:0] both;
	logic [31:0] rearm;
	logic [31:0] evt;
	logic [31:0] edge_evt;
	modport ctl (output trig_edge, output pol_fall, output both, output rearm, input lvl,
		input evt, input edge_evt);
	modport det (input trig_edge, input pol_fall, input both, input rearm, input lvl,
		output evt, output edge_evt);
	modport src (output lvl);
endinterface
`default_nettype wire

// File: logic/gpp_sync.sv
// Purpose: Three-stage pin synchroniser with input gating
// Assumes: Pins asynchronous to clk_sys
// Notes:   Change accepted when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module gpp_sync #(
	parameter int unsigned N = 32
) (
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	input  wire logic [N-1:0] pin_in,
	input  wire logic [N-1:0] rx_en,
	gpp_det_if.src            dif
);
	logic [N-1:0] s1_r, s2_r, s3_r, lvl_r;

	// The detector interface carries exactly one word of pins
	if (N != gpp_pkg::NPINS) begin : g_bad_n
		$error("gpp_sync supports exactly 32 pins");
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s1_r  <= '0;
			s2_r  <= '0;
			s3_r  <= '0;
			lvl_r <= '0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// Disabled receiver reads as constant low
			// Per pin, so one bouncing pin cannot hold back the others
			lvl_r <= ((s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r))) & rx_en;
		end
	end
	assign dif.lvl = lvl_r;
endmodule
`default_nettype wire

// File: logic/gpp_det.sv
// Purpose: Per-pin level and edge event detector
// Assumes: Levels already synchronised
// Notes:   Edge memory is the previous level only; rearm is not used here
`timescale 1ns/1ps
`default_nettype none
module gpp_det #(
	parameter int unsigned N = 32
) (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	gpp_det_if.det    dif
);
	logic [N-1:0] prev_r;

	// The detector interface carries exactly one word of pins
	if (N != gpp_pkg::NPINS) begin : g_bad_n
		$error("gpp_det supports exactly 32 pins");
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			prev_r <= '0;
		end else begin
			prev_r <= dif.lvl;
		end
	end
	for (genvar i = 0; i < N; i++) begin : g_pin
		logic rise, fall, edg, lvl_hit;
		assign rise = dif.lvl[i] & ~prev_r[i];
		assign fall = ~dif.lvl[i] & prev_r[i];
		// An edge in the clear cycle still sets the flag, so no event is lost
		assign edg = dif.both[i] ? (rise | fall) :
			(dif.pol_fall[i] ? fall : rise);
		assign lvl_hit = dif.pol_fall[i] ? ~dif.lvl[i] : dif.lvl[i];
		assign dif.evt[i] = dif.trig_edge[i] ? edg : lvl_hit;
		assign dif.edge_evt[i] = dif.trig_edge[i] & edg;
	end
endmodule
`default_nettype wire

// File: logic/gpp_port.sv
// Purpose: 32-pin port with function select, pad control and pin events
// Assumes: Register port with one-cycle read latency, never stalls
// Notes:   Pad control outputs copy their registers, except pull enables, decoded from the pull code
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module gpp_port
	import gpp_pkg::*;
#(
	parameter int unsigned N = gpp_pkg::NPINS
) (
	input  wire logic                 clk_sys,
	input  wire logic                 sys_rst,
	input  wire logic [gpp_pkg::AW-1:0] reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [31:0]          reg_rdata,
	input  wire logic [N-1:0]         pin_in,
	output logic      [N-1:0]         pin_out,
	output logic      [N-1:0]         pin_oe,
	output logic      [N-1:0]         pull_up_en,
	output logic      [N-1:0]         pull_down_en,
	output logic      [N-1:0]         pull_strong,
	output logic      [2*N-1:0]       drive_strength,
	output logic      [N-1:0]         supply_rail_sel,
	input  wire logic [N-1:0]         af1_out,
	input  wire logic [N-1:0]         af1_oe,
	input  wire logic [N-1:0]         af2_out,
	input  wire logic [N-1:0]         af2_oe,
	output logic      [N-1:0]         af1_in,
	output logic      [N-1:0]         af2_in,
	output logic                      port_irq,
	output logic                      wake_req
);
	import gpp_pkg::*;

	// Every per-pin register and the interface are fixed at one word
	if (N != NPINS) begin : g_bad_n
		$error("gpp_port supports exactly 32 pins");
	end

	// Per-pin registers, bit n serves pin n
	logic [31:0] sel0_r, sel1_r, sel2_r;
	logic [31:0] drv_en_r, drv_lvl_r, rx_en_r;
	logic [31:0] irq_en_r, irq_fl_r, trig_r, pol_r, both_r, wake_en_r;
	logic [31:0] pull0_r, pull1_r, pstr_r, ds0_r, ds1_r, rail_r;
	logic [31:0] reg_rdata_r;
	logic        port_irq_r, wake_r;
	logic [31:0] fl_nxt;

	gpp_det_if dif ();

	gpp_sync #(.N(N)) u_sync (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.pin_in  (pin_in),
		.rx_en   (rx_en_r),
		.dif     (dif)
	);

	gpp_det #(.N(N)) u_det (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.dif     (dif)
	);

	function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] b);
		hit = reg_wr && (a == b);
	endfunction

	// Plain write, set alias, clear alias
	function automatic logic [31:0] upd(input logic [31:0] cur, input logic [AW-1:0] a,
		input logic [AW-1:0] s, input logic [AW-1:0] c);
		logic [31:0] v;
		v = cur;
		if (hit(a, reg_addr)) begin
			v = reg_wdata;
		end else if (hit(s, reg_addr)) begin
			v = cur | reg_wdata;
		end else if (hit(c, reg_addr)) begin
			v = cur & ~reg_wdata;
		end
		upd = v;
	endfunction

	function automatic logic [31:0] wr(input logic [31:0] cur, input logic [AW-1:0] a);
		wr = hit(a, reg_addr) ? reg_wdata : cur;
	endfunction

	// Function select; writable any time, reset loads RST_SEL0 and zero
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sel0_r <= RST_SEL0;
		end else begin
			sel0_r <= upd(sel0_r, A_SEL0, A_SEL0_SET, A_SEL0_CLR);
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sel1_r <= ZERO32;
		end else begin
			sel1_r <= upd(sel1_r, A_SEL1, A_SEL1_SET, A_SEL1_CLR);
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sel2_r <= ZERO32;
		end else begin
			sel2_r <= upd(sel2_r, A_SEL2, A_SEL2_SET, A_SEL2_CLR);
		end
	end

	// Data and receive control
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			drv_en_r <= ZERO32;
		end else begin
			drv_en_r <= upd(drv_en_r, A_DRV_EN, A_DRV_EN_SET, A_DRV_EN_CLR);
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			drv_lvl_r <= ZERO32;
		end else begin
			drv_lvl_r <= upd(drv_lvl_r, A_DRV_LVL, A_DRV_LVL_SET, A_DRV_LVL_CLR);
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rx_en_r <= RST_RXEN;
		end else begin
			rx_en_r <= upd(rx_en_r, A_RX_EN, A_RX_EN_SET, A_RX_EN_CLR);
		end
	end

	// Pad electrical settings
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pull0_r <= ZERO32;
		end else begin
			pull0_r <= wr(pull0_r, A_PULL0);
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pull1_r <= ZERO32;
		end else begin
			pull1_r <= wr(pull1_r, A_PULL1);
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pstr_r <= ZERO32;
		end else begin
			pstr_r <= wr(pstr_r, A_PSTR);
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ds0_r <= ZERO32;
		end else begin
			ds0_r <= wr(ds0_r, A_DS0);
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ds1_r <= ZERO32;
		end else begin
			ds1_r <= wr(ds1_r, A_DS1);
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rail_r <= ZERO32;
		end else begin
			rail_r <= wr(rail_r, A_RAIL);
		end
	end

	// Interrupt configuration
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irq_en_r <= ZERO32;
		end else begin
			irq_en_r <= upd(irq_en_r, A_IRQ_EN, A_IRQ_EN_SET, A_IRQ_EN_CLR);
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			trig_r <= ZERO32;
		end else begin
			trig_r <= wr(trig_r, A_TRIG);
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pol_r <= ZERO32;
		end else begin
			pol_r <= wr(pol_r, A_POL);
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			both_r <= ZERO32;
		end else begin
			both_r <= wr(both_r, A_BOTH);
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wake_en_r <= ZERO32;
		end else begin
			wake_en_r <= wr(wake_en_r, A_WAKE_EN);
		end
	end

	assign dif.trig_edge = trig_r;
	assign dif.pol_fall  = pol_r;
	assign dif.both      = both_r;
	assign dif.rearm     = (reg_wr && reg_addr == A_IRQ_FL_CLR) ? reg_wdata : ZERO32;

	// An event in the same cycle as its clear keeps the flag set
	always_comb begin
		fl_nxt = (irq_fl_r & ~dif.rearm) | dif.evt;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irq_fl_r <= ZERO32;
		end else begin
			irq_fl_r <= fl_nxt;
		end
	end

	// Request only on an enabled 0 to 1 flag transition
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			port_irq_r <= 1'b0;
		end else begin
			port_irq_r <= |(fl_nxt & ~irq_fl_r & irq_en_r);
		end
	end

	// Only edges can wake; levels need a running clock
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wake_r <= 1'b0;
		end else begin
			wake_r <= |(dif.edge_evt & wake_en_r);
		end
	end
	assign port_irq = port_irq_r;
	assign wake_req = wake_r;

	// Pin routing per select code
	for (genvar i = 0; i < N; i++) begin : g_pin
		logic is_io, is_af1, is_af2;
		assign is_io  = sel0_r[i];
		assign is_af1 = ~sel0_r[i] & ~sel1_r[i] & ~sel2_r[i];
		assign is_af2 = ~sel0_r[i] & sel1_r[i] & ~sel2_r[i];
		assign pin_out[i] = is_io ? drv_lvl_r[i] :
			(is_af1 ? af1_out[i] : (is_af2 ? af2_out[i] : 1'b0));
		assign pin_oe[i] = is_io ? drv_en_r[i] :
			(is_af1 ? af1_oe[i] : (is_af2 ? af2_oe[i] : 1'b0));
		assign af1_in[i] = is_af1 & dif.lvl[i];
		assign af2_in[i] = is_af2 & dif.lvl[i];
		assign pull_up_en[i]   = {pull1_r[i], pull0_r[i]} == PULL_UP;
		assign pull_down_en[i] = {pull1_r[i], pull0_r[i]} == PULL_DOWN;
		assign pull_strong[i]  = pstr_r[i];
		assign drive_strength[2*i+1:2*i] = {ds1_r[i], ds0_r[i]};
	end
	assign supply_rail_sel = rail_r;

	// Readback; input level reads whatever function is active
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata_r <= ZERO32;
		end else if (!reg_rd) begin
			reg_rdata_r <= ZERO32;
		end else if (reg_addr == A_SEL0) begin
			reg_rdata_r <= sel0_r;
		end else if (reg_addr == A_SEL1) begin
			reg_rdata_r <= sel1_r;
		end else if (reg_addr == A_SEL2) begin
			reg_rdata_r <= sel2_r;
		end else if (reg_addr == A_DRV_EN) begin
			reg_rdata_r <= drv_en_r;
		end else if (reg_addr == A_DRV_LVL) begin
			reg_rdata_r <= drv_lvl_r;
		end else if (reg_addr == A_IN_LVL) begin
			reg_rdata_r <= dif.lvl;
		end else if (reg_addr == A_IRQ_EN) begin
			reg_rdata_r <= irq_en_r;
		end else if (reg_addr == A_IRQ_FL) begin
			reg_rdata_r <= irq_fl_r;
		end else if (reg_addr == A_TRIG) begin
			reg_rdata_r <= trig_r;
		end else if (reg_addr == A_POL) begin
			reg_rdata_r <= pol_r;
		end else if (reg_addr == A_RX_EN) begin
			reg_rdata_r <= rx_en_r;
		end else if (reg_addr == A_PULL0) begin
			reg_rdata_r <= pull0_r;
		end else if (reg_addr == A_PULL1) begin
			reg_rdata_r <= pull1_r;
		end else if (reg_addr == A_PSTR) begin
			reg_rdata_r <= pstr_r;
		end else if (reg_addr == A_DS0) begin
			reg_rdata_r <= ds0_r;
		end else if (reg_addr == A_DS1) begin
			reg_rdata_r <= ds1_r;
		end else if (reg_addr == A_RAIL) begin
			reg_rdata_r <= rail_r;
		end else if (reg_addr == A_BOTH) begin
			reg_rdata_r <= both_r;
		end else if (reg_addr == A_WAKE_EN) begin
			reg_rdata_r <= wake_en_r;
		end else begin
			reg_rdata_r <= ZERO32;
		end
	end
	assign reg_rdata = reg_rdata_r;
endmodule
`default_nettype wire

// File: bench/gpp_port_checker.sv
// Purpose: Port-level assertions for the pin port
// Assumes: One clock domain, write chains use back-to-back strobes
// Notes:   Pull and drive codes are checked right after their writes
`timescale 1ns/1ps
`default_nettype none
module gpp_port_checker
	import gpp_pkg::*;
#(
	parameter int unsigned N = 32
) (
	input wire logic           clk_sys,
	input wire logic           sys_rst,
	input wire logic [gpp_pkg::AW-1:0] reg_addr,
	input wire logic [31:0]    reg_wdata,
	input wire logic           reg_wr,
	input wire logic           reg_rd,
	input wire logic [31:0]    reg_rdata,
	input wire logic [N-1:0]   pin_oe,
	input wire logic [N-1:0]   pull_up_en,
	input wire logic [N-1:0]   pull_down_en,
	input wire logic [2*N-1:0] drive_strength,
	input wire logic [N-1:0]   supply_rail_sel,
	input wire logic           port_irq,
	input wire logic           wake_req
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	function automatic logic [2*N-1:0] ilv(logic [N-1:0] lo, logic [N-1:0] hi);
		for (int i = 0; i < N; i++) begin
			ilv[2*i]   = lo[i];
			ilv[2*i+1] = hi[i];
		end
	endfunction
	sequence w(logic [AW-1:0] a);
		reg_wr && reg_addr == a;
	endsequence
	sequence r(logic [AW-1:0] a);
		reg_rd && reg_addr == a;
	endsequence
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == ZERO32)
		else $error("read data not zero outside its slot");
	rd_unmapped_a: assert property (reg_rd && reg_addr > A_WAKE_EN |=> reg_rdata == ZERO32)
		else $error("unmapped read not zero");
	wr_rdback_a: assert property (w(A_WAKE_EN) ##1 r(A_WAKE_EN)
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("read back differs from write");
	clr_alias_a: assert property (w(A_DRV_LVL) ##1 w(A_DRV_LVL_SET) ##1 w(A_DRV_LVL_CLR)
		##1 r(A_DRV_LVL) |=> reg_rdata == (($past(reg_wdata, 4) | $past(reg_wdata, 3))
		& ~$past(reg_wdata, 2))) else $error("set or clear alias touched other bits");
	rail_copy_a: assert property (w(A_RAIL) |=> supply_rail_sel == $past(reg_wdata))
		else $error("rail select not applied");
	pull_code_a: assert property (w(A_PULL0) ##1 w(A_PULL1) |=>
		pull_up_en == ($past(reg_wdata, 2) & ~$past(reg_wdata))
		&& pull_down_en == (~$past(reg_wdata, 2) & $past(reg_wdata))) else $error("pull decode");
	pull_excl_a: assert property ((pull_up_en & pull_down_en) == '0)
		else $error("pull up and down together");
	drive_code_a: assert property (w(A_DS0) ##1 w(A_DS1)
		|=> drive_strength == ilv($past(reg_wdata, 2), $past(reg_wdata)))
		else $error("drive strength code misplaced");
	cover property (port_irq);
	cover property (wake_req);
	cover property (pin_oe != '0);
endmodule
bind gpp_port gpp_port_checker #(.N(N)) u_chk (.clk_sys, .sys_rst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .pin_oe, .pull_up_en, .pull_down_en, .drive_strength,
	.supply_rail_sel, .port_irq, .wake_req);
`default_nettype wire

// File: bench/gpp_pad_model.sv
// Purpose: Pad ring and external drivers around the port
// Assumes: Device drive wins over the external driver
// Notes:   Floating pads toggle every cycle so stale levels never match
`timescale 1ns/1ps
`default_nettype none
module gpp_pad_model #(
	parameter int unsigned N = 32
) (
	input  wire logic         clk_sys,
	input  wire logic [N-1:0] pin_out,
	input  wire logic [N-1:0] pin_oe,
	input  wire logic [N-1:0] pull_up_en,
	input  wire logic [N-1:0] pull_down_en,
	input  wire logic [N-1:0] ext_en,
	input  wire logic [N-1:0] ext_val,
	output logic      [N-1:0] pin_in
);
	logic [N-1:0] flt_r;
	initial flt_r = '0;
	always @(posedge clk_sys) flt_r <= ~flt_r;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pull_up_en | (~pull_down_en & flt_r)));
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Purpose: Self-checking bench for the pin port
// Assumes: All 32 pins bonded, peripherals given random words
// Notes:   Register shadow keyed by base offset follows every write
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("FAIL %0t got %h exp %h", $time, a, b); end end
module testbench;
	import gpp_pkg::*;
	logic                       clk_sys, sys_rst, reg_wr, reg_rd, port_irq, wake_req, hit, wk;
	logic [AW-1:0]              reg_addr;
	logic [31:0]                reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, d;
	logic [31:0]                pull_up_en, pull_down_en, ext_en, ext_val;
	logic [31:0]                af1_out, af1_oe, af2_out, af2_oe, af1_in, af2_in, pull_strong;
	int                         miscompares, num_checks;
	logic [31:0]                sh[logic [7:0]];
	bit                         al[logic [7:0]];
	logic [7:0]                 ab[7] = '{A_SEL0, A_DRV_EN, A_DRV_LVL, A_IRQ_EN, A_SEL1, A_SEL2, A_RX_EN};
	logic [7:0]                 pr[10] = '{A_TRIG, A_POL, A_PULL0, A_PULL1, A_PSTR, A_DS0, A_DS1,
		A_RAIL, A_BOTH, A_WAKE_EN};
	// Pin 0 event table: edge, falling, both, start level, end level
	logic [4:0]                 im[5] = '{5'h0A, 5'h01, 5'h11, 5'h1A, 5'h16};
	gpp_port DUT (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.pin_in, .pin_out, .pin_oe, .pull_up_en, .pull_down_en, .pull_strong,
		.drive_strength(), .supply_rail_sel(), .af1_out, .af1_oe, .af2_out, .af2_oe,
		.af1_in, .af2_in, .port_irq, .wake_req);
	gpp_pad_model PADS (.clk_sys, .pin_out, .pin_oe, .pull_up_en, .pull_down_en, .ext_en,
		.ext_val, .pin_in);
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		{reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b10, a, v};
		if (al.exists(a - 8'h04)) sh[a - 8'h04] |= v;
		else if (al.exists(a - 8'h08)) sh[a - 8'h08] &= ~v;
		else if (sh.exists(a)) sh[a] = v;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		{reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b01, a, ZERO32};
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic chk(input logic [7:0] a);
		rd(a, d);
		`CHK(d, sh[a])
	endtask
	task automatic idle();
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clk_sys);
		miscompares++;
		final_report();
	end
	initial begin
		sys_rst = 1'b1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{af1_out, af1_oe, af2_out, af2_oe, ext_en, ext_val} = '0;
		void'($urandom(32'h0000_e531));
		foreach (ab[i]) begin
			sh[ab[i]] = ZERO32;
			al[ab[i]] = 1'b1;
		end
		foreach (pr[i]) sh[pr[i]] = ZERO32;
		// Pins 28 and 29 start on the primary alternate function
		sh[A_SEL0] = 32'hCFFF_FFFF;
		sh[A_RX_EN] = 32'hFFFF_FFFF;
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		foreach (ab[i]) chk(ab[i]);
		foreach (pr[i]) chk(pr[i]);
		chk(A_SEL0);
		`CHK(pin_oe | pull_up_en | pull_down_en, ZERO32)
		foreach (ab[i]) begin
			wr(ab[i], $urandom());
			wr(ab[i] + 8'h04, $urandom());
			wr(ab[i] + 8'h08, $urandom());
			chk(ab[i]);
		end
		foreach (pr[i]) wr(pr[i], $urandom());
		for (int i = 9; i >= 0; i--) chk(pr[i]);
		`CHK(pull_strong, sh[A_PSTR])
		rd(8'h90, d);
		`CHK(d, ZERO32)
		wr(A_SEL2, ZERO32);
		for (int m = 3; m >= 0; m--) begin
			idle();
			{af1_out, af1_oe, af2_out, af2_oe} <= {$urandom(), $urandom(), $urandom(), $urandom()};
			wr(A_SEL0, {32{m[1]}});
			wr(A_SEL1, {32{m[0]}});
			idle();
			#1;
			`CHK(pin_out, m[1] ? sh[A_DRV_LVL] : m[0] ? af2_out : af1_out)
			`CHK(pin_oe, m[1] ? sh[A_DRV_EN] : m[0] ? af2_oe : af1_oe)
		end
		@(posedge clk_sys);
		{af1_oe, ext_en, ext_val} <= {ZERO32, ALL_ONES, $urandom()};
		wr(A_RX_EN, $urandom());
		idle();
		repeat (6) @(posedge clk_sys);
		rd(A_IN_LVL, d);
		`CHK(d, ext_val & sh[A_RX_EN])
		`CHK(af1_in, ext_val & sh[A_RX_EN])
		`CHK(af2_in, ZERO32)
		wr(A_RX_EN, ALL_ONES);
		wr(A_SEL0, ALL_ONES);
		wr(A_DRV_EN, ZERO32);
		foreach (im[k]) begin
			idle();
			ext_val[0] <= im[k][1];
			wr(A_IRQ_EN, ZERO32);
			wr(A_TRIG, {31'h0000_0000, im[k][4]});
			wr(A_POL, {31'h0000_0000, im[k][3]});
			wr(A_BOTH, {31'h0000_0000, im[k][2]});
			wr(A_WAKE_EN, 32'h0000_0001);
			idle();
			repeat (8) @(posedge clk_sys);
			wr(A_IRQ_FL_CLR, ALL_ONES);
			rd(A_IRQ_FL, d);
			`CHK(d, {ext_val[31:1], 1'b0})
			wr(A_IRQ_EN, 32'h0000_0001);
			idle();
			ext_val[0] <= im[k][0];
			{hit, wk} = 2'b00;
			for (int c = 0; c < 20; c++) begin
				@(posedge clk_sys);
				#1;
				hit |= port_irq;
				wk |= wake_req;
			end
			`CHK(hit, 1'b1)
			`CHK(wk, im[k][4])
			rd(A_IRQ_FL, d);
			`CHK(d, {ext_val[31:1], 1'b1})
		end
		final_report();
	end
endmodule
`default_nettype wire
